// ---- semaphore_manager.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "sem_defines.svh"

module semaphore_manager #(
  parameter int   NT            = `SEM_THREADS,
  parameter int   VW            = `SEM_VALUE_WIDTH,
  parameter logic LEGACY_SINGLE = `SEM_LEGACY_SINGLE,
  parameter int   TW            = $clog2(NT)
) (
  input  wire logic           i_clk,
  input  wire logic           i_resetn,
  input  wire logic           i_ce,
  sem_link_if.device          link,
  output logic      [NT-1:0]  o_pending,
  output logic      [NT-1:0]  o_owns_any
);
  localparam int NQ = `SEM_QUEUES;
  localparam int NS = `SEM_SLOTS;

  typedef struct packed {
    logic [NT-1:0][NS-1:0]         held;
    logic [NT-1:0][NS-1:0][VW-1:0] held_value;
    logic [NT-1:0]                 pend;
    logic [NT-1:0][VW-1:0]         pend_value;
    logic [NT-1:0][NQ-1:0]         ord_en;
    logic [NT-1:0][NQ-1:0]         used;
    logic [NQ-1:0][NT-1:0][TW-1:0] rq;
    logic [NQ-1:0][TW-1:0]         head;
    logic [NQ-1:0][TW-1:0]         tail;
    logic [NQ-1:0][TW:0]           cnt;
    logic [NT-1:0]                 done;
    logic [NT-1:0]                 err;
    logic                          label_error;
    logic [NT-1:0]                 pending_out;
    logic [NT-1:0]                 owns_out;
  } mgr_state_type;

  mgr_state_type s;
  mgr_state_type next_s;

  logic [NT-1:0] act;
  logic [NT-1:0] v_busy;
  logic [NT-1:0] p_taken;
  logic [NT-1:0] at_head;
  logic [NT-1:0] lock_bad;
  logic [NT-1:0] lock_req;
  logic [NT-1:0] lock_win;

  initial begin
    if (NT < 2 || (1 << TW) != NT) $error("thread count must be a power of two");
    if (VW != 32) $error("semaphore values are 32 bits");
  end

  // ----------------------------------------------------------------------------
  // request qualification
  // ----------------------------------------------------------------------------
  always_comb begin
    sem_pkg::op_type op;
    logic            q;
    logic            full;
    op       = sem_pkg::SEM_LOCK;
    q        = 1'b0;
    full     = 1'b0;
    act      = '0;
    v_busy   = '0;
    p_taken  = '0;
    at_head  = '0;
    lock_bad = '0;
    lock_req = '0;
    for (int t = 0; t < NT; t++) begin
      op = sem_pkg::op_type'(link.cmd_op[t]);
      q  = link.cmd_order_queue_select[t];
      // a thread already answered this cycle is ignored until its request drops
      act[t] = link.cmd_valid[t] && !s.done[t] && !s.pend[t];
      for (int u = 0; u < NT; u++) begin
        for (int k = 0; k < NS; k++) begin
          if (s.held[u][k] && s.held_value[u][k] == link.cmd_value[t]) v_busy[t] = 1'b1;
        end
        if (s.pend[u] && s.pend_value[u] == link.cmd_value[t]) p_taken[t] = 1'b1;
      end
      at_head[t] = (s.cnt[q] != '0) && (s.rq[q][s.head[q]] == TW'(t));
      full = &s.held[t] || (LEGACY_SINGLE && (|s.ord_en[t]) && (|s.held[t]));
      lock_bad[t] = act[t] && op == sem_pkg::SEM_LOCK &&
                    (full || (link.cmd_ordered[t] && (!s.ord_en[t][q] || s.used[t][q])));
      if (act[t] && op == sem_pkg::SEM_LOCK && !lock_bad[t]) begin
        if (link.cmd_ordered[t]) begin
          lock_req[t] = at_head[t] && (!v_busy[t] || !p_taken[t]);
        end else begin
          lock_req[t] = !v_busy[t];
        end
      end
    end
  end

  // ordered heads and unordered locks meet in one round-robin
  sem_rr_arbiter #(.N(NT)) u_arb (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_req    (lock_req),
    .o_grant  (lock_win)
  );

  // ----------------------------------------------------------------------------
  // next state: lock, unlock and release all act in the same cycle
  // ----------------------------------------------------------------------------
  always_comb begin
    sem_pkg::op_type      op;
    logic                 q;
    logic                 hit;
    logic                 d_en;
    logic [NQ-1:0]        pop;
    logic [NQ-1:0]        push;
    logic [NT-1:0]        unl;
    op     = sem_pkg::SEM_LOCK;
    q      = 1'b0;
    hit    = 1'b0;
    d_en   = 1'b0;
    pop    = '0;
    push   = '0;
    unl    = '0;
    next_s = s;
    next_s.done        = '0;
    next_s.err         = '0;
    next_s.label_error = 1'b0;

    for (int t = 0; t < NT; t++) begin
      op  = sem_pkg::op_type'(link.cmd_op[t]);
      q   = link.cmd_order_queue_select[t];
      hit = 1'b0;
      if (act[t] && op == sem_pkg::SEM_UNLOCK) begin
        for (int k = 0; k < NS; k++) begin
          if (!hit && s.held[t][k] && s.held_value[t][k] == link.cmd_value[t]) begin
            hit                = 1'b1;
            next_s.held[t][k]  = 1'b0;
          end
        end
        unl[t]         = hit;
        next_s.err[t]  = !hit;
        next_s.done[t] = 1'b1;
      end
      if (act[t] && op == sem_pkg::SEM_RELEASE) begin
        if (!s.ord_en[t][q] || s.used[t][q]) begin
          next_s.done[t] = 1'b1;
        end else if (at_head[t]) begin
          pop[q]            = 1'b1;
          next_s.used[t][q] = 1'b1;
          next_s.done[t]    = 1'b1;
        end
      end
      if (lock_bad[t]) begin
        next_s.err[t]  = 1'b1;
        next_s.done[t] = 1'b1;
      end
      if (lock_win[t]) begin
        if (link.cmd_ordered[t]) begin
          pop[q]            = 1'b1;
          next_s.used[t][q] = 1'b1;
        end
        if (v_busy[t]) begin
          // the queue moves on so later frames may lock other values
          next_s.pend[t]       = 1'b1;
          next_s.pend_value[t] = link.cmd_value[t];
        end else begin
          next_s.held[t][s.held[t][0] ? 1 : 0]       = 1'b1;
          next_s.held_value[t][s.held[t][0] ? 1 : 0] = link.cmd_value[t];
          next_s.done[t]                             = 1'b1;
        end
      end
    end

    // a freed value passes straight to its pending thread; one parked this cycle is answered too,
    // but its slot takes the old s.pend_value, so a lock parked beside the unlock of its value does not wait forever
    for (int p = 0; p < NT; p++) begin
      for (int u = 0; u < NT; u++) begin
        if (next_s.pend[p] && unl[u] && link.cmd_value[u] == next_s.pend_value[p]) begin
          next_s.pend[p]                             = 1'b0;
          next_s.held[p][s.held[p][0] ? 1 : 0]       = 1'b1;
          next_s.held_value[p][s.held[p][0] ? 1 : 0] = s.pend_value[p];
          next_s.done[p]                             = 1'b1;
        end
      end
    end

    if (link.disp_valid) begin
      for (int k = 0; k < NQ; k++) begin
        d_en = link.disp_label_generation_flag && link.ordered_enable[k];
        next_s.ord_en[link.disp_thread][k] = d_en;
        next_s.used[link.disp_thread][k]   = 1'b0;
        push[k]                            = d_en;
      end
    end

    if (link.label_release) begin
      for (int k = 0; k < NQ; k++) begin
        if (s.ord_en[link.label_thread][k] && !s.used[link.label_thread][k]) begin
          next_s.label_error = 1'b1;
        end
      end
    end

    for (int k = 0; k < NQ; k++) begin
      if (pop[k]) next_s.head[k] = s.head[k] + TW'(1);
      if (push[k]) begin
        next_s.rq[k][s.tail[k]] = link.disp_thread;
        next_s.tail[k]          = s.tail[k] + TW'(1);
      end
      next_s.cnt[k] = s.cnt[k] + (TW+1)'(push[k]) - (TW+1)'(pop[k]);
    end

    next_s.pending_out = next_s.pend;
    for (int t = 0; t < NT; t++) begin
      next_s.owns_out[t] = |next_s.held[t];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s <= '0;
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------------------
  assign link.done        = s.done;
  assign link.err         = s.err;
  assign link.label_error = s.label_error;
  assign o_pending        = s.pending_out;
  assign o_owns_any       = s.owns_out;
endmodule : semaphore_manager

`default_nettype wire

// ---- sem_defines.svh ----
`ifndef SEM_DEFINES_SVH
`define SEM_DEFINES_SVH

// ----------------------------------------------------------------------------
// sizes and reset values
// ----------------------------------------------------------------------------
`define SEM_VALUE_WIDTH   32
`define SEM_THREADS       4
`define SEM_QUEUES        2
`define SEM_SLOTS         2
`define SEM_LEGACY_SINGLE 1'b0
`define SEM_ENABLE_RESET  2'h0

`endif

// ---- sem_pkg.sv ----
package sem_pkg;

  // ----------------------------------------------------------------------------
  // command codes carried on the link
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SEM_LOCK    = 2'h0,
    SEM_UNLOCK  = 2'h1,
    SEM_RELEASE = 2'h2
  } op_type;

endpackage : sem_pkg

// ---- sem_link_if.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "sem_defines.svh"

interface sem_link_if #(
  parameter int NT = `SEM_THREADS,
  parameter int VW = `SEM_VALUE_WIDTH,
  parameter int TW = $clog2(NT)
);
  logic [NT-1:0]                cmd_valid;
  logic [NT-1:0][1:0]           cmd_op;
  logic [NT-1:0][VW-1:0]        cmd_value;
  logic [NT-1:0]                cmd_ordered;
  logic [NT-1:0]                cmd_order_queue_select;
  logic [NT-1:0]                done;
  logic [NT-1:0]                err;
  logic                         disp_valid;
  logic [TW-1:0]                disp_thread;
  logic                         disp_label_generation_flag;
  logic [`SEM_QUEUES-1:0]       ordered_enable;
  logic                         label_release;
  logic [TW-1:0]                label_thread;
  logic                         label_error;

  modport device (
    input  cmd_valid, cmd_op, cmd_value, cmd_ordered, cmd_order_queue_select,
    input  disp_valid, disp_thread, disp_label_generation_flag, ordered_enable,
    input  label_release, label_thread,
    output done, err, label_error
  );

  modport coproc (
    output cmd_valid, cmd_op, cmd_value, cmd_ordered, cmd_order_queue_select,
    output disp_valid, disp_thread, disp_label_generation_flag, ordered_enable,
    output label_release, label_thread,
    input  done, err, label_error
  );
endinterface : sem_link_if

`default_nettype wire

// ---- sem_rr_arbiter.sv ----
`timescale 1ns/1ns
`default_nettype none

module sem_rr_arbiter #(
  parameter int N  = 4,
  parameter int PW = $clog2(N)
) (
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_ce,
  input  wire logic [N-1:0] i_req,
  output logic      [N-1:0] o_grant
);
  typedef struct packed {
    logic [PW-1:0] ptr;
  } arb_state_type;

  arb_state_type s;
  arb_state_type next_s;

  initial begin
    if (N < 2 || (1 << PW) != N) $error("arbiter width must be a power of two");
  end

  // ----------------------------------------------------------------------------
  // search from the pointer; the pointer moves past the winner for fairness
  // ----------------------------------------------------------------------------
  always_comb begin
    int idx;
    logic found;
    idx     = 0;
    found   = 1'b0;
    next_s  = s;
    o_grant = '0;
    for (int i = 0; i < N; i++) begin
      idx = (int'(s.ptr) + i) % N;
      if (!found && i_req[idx]) begin
        found        = 1'b1;
        o_grant[idx] = 1'b1;
        next_s.ptr   = PW'(idx + 1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s <= '0;
    end else if (i_ce) begin
      s <= next_s;
    end
  end
endmodule : sem_rr_arbiter

`default_nettype wire

// ---- semaphore_coproc.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "sem_defines.svh"

module semaphore_coproc #(
  parameter int NT = `SEM_THREADS,
  parameter int VW = `SEM_VALUE_WIDTH,
  parameter int TW = $clog2(NT)
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_resetn,
  input  wire logic                    i_ce,
  sem_link_if.coproc                   link,
  input  wire logic [NT-1:0]           i_req_valid,
  input  wire logic [NT-1:0][1:0]      i_req_op,
  input  wire logic [NT-1:0][VW-1:0]   i_req_value,
  input  wire logic [NT-1:0]           i_req_ordered,
  input  wire logic [NT-1:0]           i_req_order_queue_select,
  input  wire logic                    i_dispatch_valid,
  input  wire logic [TW-1:0]           i_dispatch_thread,
  input  wire logic                    i_label_generation_flag,
  input  wire logic [`SEM_QUEUES-1:0]  i_ordered_enable,
  input  wire logic                    i_label_release,
  input  wire logic [TW-1:0]           i_label_thread,
  output logic      [NT-1:0]           o_busy,
  output logic      [NT-1:0]           o_resp_done,
  output logic      [NT-1:0]           o_resp_err,
  output logic                         o_label_error
);
  typedef struct packed {
    logic [NT-1:0]              valid;
    logic [NT-1:0][1:0]         op;
    logic [NT-1:0][VW-1:0]      value;
    logic [NT-1:0]              ordered;
    logic [NT-1:0]              qsel;
    logic [NT-1:0]              resp_done;
    logic [NT-1:0]              resp_err;
    logic                       disp_valid;
    logic [TW-1:0]              disp_thread;
    logic                       disp_flag;
    logic [`SEM_QUEUES-1:0]     enable;
    logic                       lab_rel;
    logic [TW-1:0]              lab_thread;
    logic                       lab_err;
  } cop_state_type;

  cop_state_type s;
  cop_state_type next_s;

  initial begin
    if (NT < 2 || (1 << TW) != NT) $error("thread count must be a power of two");
  end

  // ----------------------------------------------------------------------------
  // one outstanding command per thread, held until answered
  // ----------------------------------------------------------------------------
  always_comb begin
    next_s            = s;
    next_s.resp_done  = link.done & s.valid;
    next_s.resp_err   = link.err & s.valid;
    next_s.valid      = s.valid & ~link.done;
    for (int t = 0; t < NT; t++) begin
      // a new request is dropped while the previous one is still outstanding, including the cycle its done arrives
      if (!s.valid[t] && i_req_valid[t]) begin
        next_s.valid[t]   = 1'b1;
        next_s.op[t]      = i_req_op[t];
        next_s.value[t]   = i_req_value[t];
        next_s.ordered[t] = i_req_ordered[t];
        next_s.qsel[t]    = i_req_order_queue_select[t];
      end
    end
    next_s.disp_valid  = i_dispatch_valid;
    next_s.disp_thread = i_dispatch_thread;
    next_s.disp_flag   = i_label_generation_flag;
    next_s.enable      = i_ordered_enable;
    // software drives unused reservations out through the release command
    next_s.lab_rel     = i_label_release;
    next_s.lab_thread  = i_label_thread;
    next_s.lab_err     = link.label_error;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s        <= '0;
      s.enable <= `SEM_ENABLE_RESET;
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  assign link.cmd_valid                  = s.valid;
  assign link.cmd_op                     = s.op;
  assign link.cmd_value                  = s.value;
  assign link.cmd_ordered                = s.ordered;
  assign link.cmd_order_queue_select     = s.qsel;
  assign link.disp_valid                 = s.disp_valid;
  assign link.disp_thread                = s.disp_thread;
  assign link.disp_label_generation_flag = s.disp_flag;
  assign link.ordered_enable             = s.enable;
  assign link.label_release              = s.lab_rel;
  assign link.label_thread               = s.lab_thread;
  assign o_busy                          = s.valid;
  assign o_resp_done                     = s.resp_done;
  assign o_resp_err                      = s.resp_err;
  assign o_label_error                   = s.lab_err;
endmodule : semaphore_coproc

`default_nettype wire

// ---- sem_link_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// link checker
// ----------------------------------------
module sem_link_properties #(
  parameter int NT = 4,
  parameter int VW = 32
) (
  input wire logic                   i_clk,
  input wire logic                   i_resetn,
  input wire logic [NT-1:0]          cmd_valid,
  input wire logic [NT-1:0][1:0]     cmd_op,
  input wire logic [NT-1:0][VW-1:0]  cmd_value,
  input wire logic [NT-1:0]          done,
  input wire logic [NT-1:0]          err,
  input wire logic                   label_release,
  input wire logic                   label_error
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic [NT-1:0][1:0]          hv;
  logic [NT-1:0][1:0][VW-1:0]  hval;
  logic [NT-1:0]               lk;
  logic [NT-1:0]               ul;
  logic [NT-1:0]               clash;
  // ownership mirror; a value freed this cycle may change hands in the same cycle
  always_comb begin
    clash = '0;
    for (int t = 0; t < NT; t++) begin
      lk[t] = done[t] && !err[t] && cmd_op[t] == sem_pkg::SEM_LOCK;
      ul[t] = done[t] && !err[t] && cmd_op[t] == sem_pkg::SEM_UNLOCK;
    end
    for (int t = 0; t < NT; t++)
      for (int u = 0; u < NT; u++)
        if (u != t) begin
          for (int s = 0; s < 2; s++)
            if (hv[u][s] && hval[u][s] == cmd_value[t] && !(ul[u] && cmd_value[u] == cmd_value[t]))
              clash[t] = 1'b1;
          if (lk[u] && cmd_value[u] == cmd_value[t])
            clash[t] = 1'b1;
        end
  end
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hv <= '0;
      hval <= '0;
    end else begin
      for (int t = 0; t < NT; t++) begin
        if (lk[t]) begin
          hv[t][hv[t][0]] <= 1'b1;
          hval[t][hv[t][0]] <= cmd_value[t];
        end
        for (int s = 0; s < 2; s++)
          if (ul[t] && hv[t][s] && hval[t][s] == cmd_value[t])
            hv[t][s] <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // per thread properties
  // ----------------------------------------
  for (genvar t = 0; t < NT; t++) begin : g_thr
    sequence s_unlock_start;
      $rose(cmd_valid[t]) && cmd_op[t] == sem_pkg::SEM_UNLOCK;
    endsequence
    property p_exclusive;
      lk[t] |-> !clash[t];
    endproperty
    property p_two_slots;
      lk[t] |-> !(hv[t][0] && hv[t][1]);
    endproperty
    property p_done_cause;
      done[t] |-> $past(cmd_valid[t]);
    endproperty
    property p_done_pulse;
      done[t] |=> !done[t];
    endproperty
    property p_err_with_done;
      err[t] |-> done[t];
    endproperty
    // unlock is never queued behind a waiting lock
    property p_unlock_fast;
      s_unlock_start |=> done[t];
    endproperty
    property p_hold;
      cmd_valid[t] && !done[t] |=> cmd_valid[t] && $stable(cmd_value[t]) && $stable(cmd_op[t]);
    endproperty
    a_exclusive: assert property (p_exclusive) else $error("lock granted on owned value");
    a_two_slots: assert property (p_two_slots) else $error("third value granted");
    a_done_cause: assert property (p_done_cause) else $error("done without command");
    a_done_pulse: assert property (p_done_pulse) else $error("done held two cycles");
    a_err_with_done: assert property (p_err_with_done) else $error("err without done");
    a_unlock_fast: assert property (p_unlock_fast) else $error("unlock delayed");
    a_hold: assert property (p_hold) else $error("command changed before done");
  end
  property p_label_error;
    label_error |-> $past(label_release);
  endproperty
  a_label_error: assert property (p_label_error) else $error("label error without release");
endmodule : sem_link_properties
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int NT = 4;
  localparam logic [1:0] LK = sem_pkg::SEM_LOCK;
  localparam logic [1:0] UL = sem_pkg::SEM_UNLOCK;
  localparam logic [1:0] RL = sem_pkg::SEM_RELEASE;
  logic                 clk, resetn, dv, df, lr, le, got, got1;
  logic [1:0]           dt, lt, oe;
  logic [NT-1:0]        rv, ro, rq, busy, rd, re, pend, owns, s;
  logic [NT-1:0][1:0]   rop;
  logic [NT-1:0][31:0]  rval;
  logic [31:0]          pool [4];
  logic [31:0]          hold [NT][2];
  logic                 hv   [NT][2];
  logic [31:0]          v;
  int                   miscompares, num_checks, t, h, w;
  sem_link_if #(.NT(NT), .VW(32)) sem_link_if_i ();
  semaphore_manager #(.NT(NT)) semaphore_manager_i (.i_clk(clk), .i_resetn(resetn), .i_ce(1'b1),
    .link(sem_link_if_i), .o_pending(pend), .o_owns_any(owns));
  semaphore_coproc #(.NT(NT)) semaphore_coproc_i (.i_clk(clk), .i_resetn(resetn), .i_ce(1'b1),
    .link(sem_link_if_i), .i_req_valid(rv), .i_req_op(rop), .i_req_value(rval), .i_req_ordered(ro),
    .i_req_order_queue_select(rq), .i_dispatch_valid(dv), .i_dispatch_thread(dt),
    .i_label_generation_flag(df), .i_ordered_enable(oe), .i_label_release(lr), .i_label_thread(lt),
    .o_busy(busy), .o_resp_done(rd), .o_resp_err(re), .o_label_error(le));
  sem_link_properties #(.NT(NT), .VW(32)) sem_link_properties_i (.i_clk(clk), .i_resetn(resetn),
    .cmd_valid(sem_link_if_i.cmd_valid), .cmd_op(sem_link_if_i.cmd_op), .cmd_value(sem_link_if_i.cmd_value),
    .done(sem_link_if_i.done), .err(sem_link_if_i.err), .label_release(sem_link_if_i.label_release),
    .label_error(sem_link_if_i.label_error));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic int holder(input logic [31:0] x);
    holder = -1;
    for (int i = 0; i < NT; i++)
      for (int j = 0; j < 2; j++)
        if (hv[i][j] && hold[i][j] == x) holder = i;
  endfunction : holder
  function automatic int count(input int i);
    count = int'(hv[i][0]) + int'(hv[i][1]);
  endfunction : count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic print_verdict;
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  task automatic send(input int i, input logic [1:0] op, input logic [31:0] x, input logic o, input logic q);
    for (int n = 0; n < 50 && busy[i] !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    rv[i] = 1'b1;
    rop[i] = op;
    rval[i] = x;
    ro[i] = o;
    rq[i] = q;
    @(posedge clk);
    #1;
    check("busy", busy[i], 1'b1);
    rv[i] = 1'b0;
  endtask : send
  task automatic wait_resp(input int i, input logic e, output logic g);
    g = 1'b0;
    for (int n = 0; n < 40 && !g; n++) begin
      @(posedge clk);
      #1;
      if (rd[i] === 1'b1) begin
        g = 1'b1;
        check("resp_err", re[i], e);
      end
    end
  endtask : wait_resp
  task automatic do_cmd(input int i, input logic [1:0] op, input logic [31:0] x, input logic o, input logic q,
                        input logic e);
    logic g;
    send(i, op, x, o, q);
    wait_resp(i, e, g);
    check("resp_done", g, 1'b1);
  endtask : do_cmd
  task automatic wait_any(input logic [NT-1:0] m, output logic [NT-1:0] r);
    r = '0;
    for (int n = 0; n < 40 && r == '0; n++) begin
      @(posedge clk);
      #1;
      r = rd & m;
    end
  endtask : wait_any
  task automatic dispatch(input int i, input logic f);
    dv = 1'b1;
    dt = 2'(i);
    df = f;
    @(posedge clk);
    #1;
    dv = 1'b0;
    @(posedge clk);
    #1;
  endtask : dispatch
  // ----------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // generous bound: the whole sequence needs a few hundred cycles
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
  initial begin
    {resetn, dv, df, lr, dt, lt, oe, rv, ro, rq, rop, rval} = '0;
    miscompares = 0;
    num_checks = 0;
    for (int i = 0; i < NT; i++) hv[i] = '{1'b0, 1'b0};
    void'($urandom(32'hc6fe01b0));
    repeat (3) @(posedge clk);
    #1;
    resetn = 1'b1;
    // corner values plus two random neighbours one bit apart
    pool[0] = 32'h0;
    pool[1] = 32'hffffffff;
    pool[2] = $urandom;
    pool[3] = pool[2] ^ 32'h1;
    for (int i = 0; i < 60; i++) begin
      t = $urandom_range(NT - 1);
      v = pool[$urandom_range(3)];
      h = holder(v);
      if (h == t) begin
        do_cmd(t, UL, v, 1'b0, 1'b0, 1'b0);
        for (int j = 0; j < 2; j++) if (hold[t][j] == v) hv[t][j] = 1'b0;
      end else if (h >= 0) begin
        do_cmd(t, UL, v, 1'b0, 1'b0, 1'b1);
      end else begin
        do_cmd(t, LK, v, 1'b0, 1'b0, count(t) == 2);
        if (count(t) < 2) begin
          w = hv[t][0] ? 1 : 0;
          hold[t][w] = v;
          hv[t][w] = 1'b1;
        end
      end
      check("owns_any", owns[t], count(t) > 0);
    end
    for (int i = 0; i < NT; i++)
      for (int j = 0; j < 2; j++)
        if (hv[i][j]) do_cmd(i, UL, hold[i][j], 1'b0, 1'b0, 1'b0);
    // contention and fairness
    v = pool[2];
    do_cmd(0, LK, v, 1'b0, 1'b0, 1'b0);
    fork
      send(1, LK, v, 1'b0, 1'b0);
      send(2, LK, v, 1'b0, 1'b0);
    join
    repeat (10) begin
      @(posedge clk);
      #1;
      check("held_off", rd[2:1], 2'h0);
    end
    do_cmd(0, UL, v, 1'b0, 1'b0, 1'b0);
    wait_any(4'h6, s);
    check("one_grant", $onehot(s), 1'b1);
    w = s[1] ? 1 : 2;
    do_cmd(w, UL, v, 1'b0, 1'b0, 1'b0);
    wait_any(4'h6, s);
    check("rr_grant", s, 4'(1 << (3 - w)));
    send(w, LK, v, 1'b0, 1'b0);
    do_cmd(3 - w, UL, v, 1'b0, 1'b0, 1'b0);
    wait_resp(w, 1'b0, got);
    check("regrant", got, 1'b1);
    do_cmd(w, UL, v, 1'b0, 1'b0, 1'b0);
    // ordered traffic; enables still clear
    dispatch(0, 1'b1);
    do_cmd(0, LK, pool[0], 1'b1, 1'b0, 1'b1);
    oe = 2'h3;
    for (int i = 1; i < 4; i++) dispatch(i, 1'b1);
    do_cmd(0, LK, pool[2], 1'b0, 1'b0, 1'b0);
    send(3, LK, pool[3], 1'b1, 1'b0);
    send(1, LK, pool[2], 1'b1, 1'b0);
    got = 1'b0;
    for (int n = 0; n < 20 && !got; n++) begin
      @(posedge clk);
      #1;
      got = pend[1];
      check("not_head", rd[3], 1'b0);
    end
    check("pending", got, 1'b1);
    do_cmd(2, RL, 32'h0, 1'b0, 1'b0, 1'b0);
    wait_resp(3, 1'b0, got);
    check("behind_pending", got, 1'b1);
    fork
      do_cmd(0, UL, pool[2], 1'b0, 1'b0, 1'b0);
      wait_resp(1, 1'b0, got1);
    join
    check("handoff", got1, 1'b1);
    do_cmd(3, UL, pool[3], 1'b0, 1'b0, 1'b0);
    do_cmd(3, LK, pool[3], 1'b1, 1'b0, 1'b1);
    do_cmd(1, UL, pool[2], 1'b0, 1'b0, 1'b0);
    for (int i = 1; i < 4; i++) do_cmd(i, RL, 32'h0, 1'b0, 1'b1, 1'b0);
    dispatch(2, 1'b0);
    do_cmd(2, LK, pool[3], 1'b1, 1'b0, 1'b1);
    dispatch(0, 1'b1);
    lr = 1'b1;
    lt = 2'h0;
    @(posedge clk);
    #1;
    lr = 1'b0;
    got = 1'b0;
    for (int n = 0; n < 10 && !got; n++) begin
      @(posedge clk);
      #1;
      got = le;
    end
    check("label_error", got, 1'b1);
    for (int q = 0; q < 2; q++) do_cmd(0, RL, 32'h0, 1'b0, q[0], 1'b0);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
